// *** core/jms_defines.svh ***
// Register indices, field positions and reset values of the mode and status bank.
// Assumes a 32-bit bus; every register index is multiplied by four for its byte address.
`ifndef JMS_DEFINES_SVH
`define JMS_DEFINES_SVH
`define JMS_IDX_CTRL 14'h0980
`define JMS_IDX_STAT 14'h0982
`define JMS_IDX_IEN 14'h0986
`define JMS_IDX_THR 14'h09A0
`define JMS_IDX_FSIZE 14'h09A4
`define JMS_IDX_LIM_LO 14'h09B0
`define JMS_IDX_LIM_HI 14'h09B2
`define JMS_IDX_RES_LO 14'h09B4
`define JMS_IDX_RES_HI 14'h09B6
`define JMS_B_EN 0
`define JMS_B_MODE 3:1
`define JMS_B_NOOFS 4
`define JMS_B_SWRST 7
`define JMS_B_ROT 8
`define JMS_B_FILEOUT 14
`define JMS_B_FILL 13:12
`define JMS_B_VIOL 11
`define JMS_B_TRIG 10
`define JMS_B_THR 5:4
`define JMS_STAT_RST 16'h8080
`define JMS_FILL_MIN 16'h0004
`define JMS_RESP_OKAY 2'h0
`define JMS_RESP_SLVERR 2'h2
`endif

// *** core/jms_pkg.sv ***
// Types shared by the mode and status bank.
// Assumes the constants header is included where field positions are needed.
package jms_pkg;
  typedef enum logic [1:0] {
    JMS_WR_IDLE = 2'h0, JMS_WR_ADDR = 2'h1, JMS_WR_RESP = 2'h3, JMS_WR_DATA = 2'h2
  } jms_wr_state_t;
  typedef enum logic [2:0] {
    JMS_MODE_CODEC = 3'h0, JMS_MODE_YIN_422 = 3'h1, JMS_MODE_RSVD_A = 3'h2,
    JMS_MODE_YOUT_422 = 3'h3, JMS_MODE_HOST_CODEC = 3'h4, JMS_MODE_YIN_420 = 3'h5,
    JMS_MODE_RSVD_B = 3'h6, JMS_MODE_YOUT_420 = 3'h7
  } jms_mode_t;
  typedef enum logic [1:0] {
    JMS_SRC_CAMERA = 2'h0, JMS_SRC_DISPLAY = 2'h1, JMS_SRC_HOST = 2'h2, JMS_SRC_NONE = 2'h3
  } jms_src_t;
  typedef struct packed {
    logic codec_on;
    logic bypass;
    jms_src_t enc_src;
    logic line_buf_first;
    logic dec_to_host;
    logic yuv_in;
    logic yuv_out;
    logic yuv_420;
  } jms_route_t;
  typedef struct packed {
    logic file_out;
    logic [15:0] fifo_bytes;
    logic [31:0] size_result;
  } jms_codec_stat_t;
  typedef struct packed {
    logic flag;
  } jms_flag_state_t;
  typedef struct packed {
    jms_wr_state_t wr;
    logic [13:0] widx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic mod_en;
    jms_mode_t mode;
    logic no_offset;
    logic rotate;
    logic [1:0] ien;
    logic [1:0] thr;
    logic [15:0] fifo_size;
    logic [31:0] size_limit;
    logic sw_reset;
    jms_route_t route;
    logic irq;
  } jms_state_t;
endpackage

// *** core/jms_sticky_flag.sv ***
// One sticky status flag with write-one-to-clear that holds while its cause lasts.
// Assumes cause is a synchronous level and clear and soft reset are one-cycle pulses.
module jms_sticky_flag (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic cause,
  input wire logic clear,
  input wire logic soft_reset,
  output logic flag
);
  jms_pkg::jms_flag_state_t st;
  jms_pkg::jms_flag_state_t next_st;

  // Soft reset drops the flag, a live cause sets it, a clear only lands once the cause is gone.
  always_comb begin
    next_st = st;
    if (soft_reset) begin
      next_st.flag = 1'b0;
    end else if (cause) begin
      next_st.flag = 1'b1;
    end else if (clear) begin
      next_st.flag = 1'b0;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign flag = st.flag;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_blocked_clear;
    ce && clear && cause && !soft_reset;
  endsequence

  a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cause && !soft_reset |=> flag)
    else $error("flag did not set on its cause");
  a_clear_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    s_blocked_clear |=> flag)
    else $error("flag cleared while its cause lasted");
  a_clear_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && flag && clear && !cause |=> !flag)
    else $error("write one failed to clear the flag");
  a_hold_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && flag && !clear && !soft_reset |=> flag)
    else $error("flag dropped without a clear");
endmodule // jms_sticky_flag

// *** core/jms_route_dec.sv ***
// Decodes the data-mode field into the routing of pixel and compressed data.
// Assumes reserved codes are never programmed; they route nothing.
module jms_route_dec (
  input jms_pkg::jms_mode_t mode,
  input wire logic enable,
  input jms_pkg::jms_src_t capture_src,
  output jms_pkg::jms_route_t route
);
  // Each code except the two reserved ones picks a path; the codec path is cut while the module is disabled.
  always_comb begin
    route = '0;
    route.enc_src = jms_pkg::JMS_SRC_NONE;
    unique case (mode)
      jms_pkg::JMS_MODE_CODEC: begin
        route.codec_on = enable;
        route.enc_src = capture_src;
      end
      jms_pkg::JMS_MODE_YIN_422, jms_pkg::JMS_MODE_YIN_420: begin
        route.bypass = 1'b1;
        route.yuv_in = 1'b1;
        route.yuv_420 = mode[2];
      end
      jms_pkg::JMS_MODE_YOUT_422, jms_pkg::JMS_MODE_YOUT_420: begin
        route.bypass = 1'b1;
        route.yuv_out = 1'b1;
        route.yuv_420 = mode[2];
      end
      jms_pkg::JMS_MODE_HOST_CODEC: begin
        route.codec_on = enable;
        route.enc_src = jms_pkg::JMS_SRC_HOST;
        route.line_buf_first = 1'b1;
        route.dec_to_host = 1'b1;
      end
      jms_pkg::JMS_MODE_RSVD_A, jms_pkg::JMS_MODE_RSVD_B: begin
        route.bypass = 1'b0;
      end
    endcase
  end
endmodule // jms_route_dec

// *** core/jms_top.sv ***
// Mode, enable and status bank of the image compression module, AXI4-Lite slave.
// Assumes a single clock; codec status inputs are synchronous to aclk.
`include "jms_defines.svh"
module jms_top #(
  parameter int ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input jms_pkg::jms_codec_stat_t codec_stat,
  input jms_pkg::jms_src_t capture_src,
  output jms_pkg::jms_route_t route,
  output logic module_clk_en,
  output logic module_sw_reset,
  output logic yuv_no_offset,
  output logic rotate_180,
  output logic irq
);
  jms_pkg::jms_state_t st;
  jms_pkg::jms_state_t next_st;
  jms_pkg::jms_route_t dec_route;
  logic viol_flag;
  logic trig_flag;
  logic viol_cause;
  logic trig_cause;
  logic [1:0] fill_code;
  logic aw_take;
  logic w_take;
  logic do_wr;
  logic [13:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [13:0] rd_idx;
  logic [15:0] rd_val;
  logic rd_hit;
  logic clr_viol;
  logic clr_trig;
  logic [15:0] stat_word;

  ////////////////////////////////////////////////////////////////////////////
  // Fill level code from the FIFO byte count against the configured size.
  always_comb begin
    if (codec_stat.fifo_bytes > (st.fifo_size >> 1)) begin
      fill_code = 2'h3;
    end else if (codec_stat.fifo_bytes > (st.fifo_size >> 2)) begin
      fill_code = 2'h2;
    end else if (codec_stat.fifo_bytes > `JMS_FILL_MIN) begin
      fill_code = 2'h1;
    end else begin
      fill_code = 2'h0;
    end
  end

  // Causes of the two sticky flags.
  assign viol_cause = codec_stat.size_result > st.size_limit;
  assign trig_cause = (fill_code != 2'h0) && (fill_code >= st.thr);

  // Status word; the two flags show only through their enables.
  always_comb begin
    stat_word = `JMS_STAT_RST;
    stat_word[`JMS_B_FILEOUT] = codec_stat.file_out;
    stat_word[`JMS_B_FILL] = fill_code;
    stat_word[`JMS_B_VIOL] = viol_flag & st.ien[1];
    stat_word[`JMS_B_TRIG] = trig_flag & st.ien[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data may arrive in either order.
  assign aw_take = s_axi_awvalid && st.awready;
  assign w_take = s_axi_wvalid && st.wready;

  // Write target: fresh bus values when taken now, else the held copies.
  always_comb begin
    wr_idx = aw_take ? s_axi_awaddr[15:2] : st.widx;
    wr_data = w_take ? s_axi_wdata : st.wdata;
    wr_strb = w_take ? s_axi_wstrb : st.wstrb;
    unique case (st.wr)
      jms_pkg::JMS_WR_IDLE: do_wr = aw_take && w_take;
      jms_pkg::JMS_WR_ADDR: do_wr = w_take;
      jms_pkg::JMS_WR_DATA: do_wr = aw_take;
      jms_pkg::JMS_WR_RESP: do_wr = 1'b0;
    endcase
  end

  // Write-one-to-clear pulses for the status flags.
  assign clr_viol = do_wr && wr_idx == `JMS_IDX_STAT && wr_strb[1] && wr_data[`JMS_B_VIOL];
  assign clr_trig = do_wr && wr_idx == `JMS_IDX_STAT && wr_strb[1] && wr_data[`JMS_B_TRIG];

  ////////////////////////////////////////////////////////////////////////////
  // Read decode over the mapped registers; anything else answers an error.
  assign rd_idx = s_axi_araddr[15:2];
  always_comb begin
    rd_val = 16'h0000;
    rd_hit = 1'b1;
    unique case (rd_idx)
      `JMS_IDX_CTRL: begin
        rd_val[`JMS_B_EN] = st.mod_en;
        rd_val[`JMS_B_MODE] = st.mode;
        rd_val[`JMS_B_NOOFS] = st.no_offset;
        rd_val[`JMS_B_ROT] = st.rotate;
      end
      `JMS_IDX_STAT: rd_val = stat_word;
      `JMS_IDX_IEN: begin
        rd_val[`JMS_B_VIOL] = st.ien[1];
        rd_val[`JMS_B_TRIG] = st.ien[0];
      end
      `JMS_IDX_THR: rd_val[`JMS_B_THR] = st.thr;
      `JMS_IDX_FSIZE: rd_val = st.fifo_size;
      `JMS_IDX_LIM_LO: rd_val = st.size_limit[15:0];
      `JMS_IDX_LIM_HI: rd_val = st.size_limit[31:16];
      `JMS_IDX_RES_LO: rd_val = codec_stat.size_result[15:0];
      `JMS_IDX_RES_HI: rd_val = codec_stat.size_result[31:16];
      default: rd_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic of the bank; the two sticky flags keep their own.
  always_comb begin
    next_st = st;
    next_st.sw_reset = 1'b0;
    // Write handshake sequencing.
    unique case (st.wr)
      jms_pkg::JMS_WR_IDLE: begin
        if (aw_take && w_take) begin
          next_st.wr = jms_pkg::JMS_WR_RESP;
        end else if (aw_take) begin
          next_st.wr = jms_pkg::JMS_WR_ADDR;
        end else if (w_take) begin
          next_st.wr = jms_pkg::JMS_WR_DATA;
        end
      end
      jms_pkg::JMS_WR_ADDR: begin
        if (w_take) begin
          next_st.wr = jms_pkg::JMS_WR_RESP;
        end
      end
      jms_pkg::JMS_WR_DATA: begin
        if (aw_take) begin
          next_st.wr = jms_pkg::JMS_WR_RESP;
        end
      end
      jms_pkg::JMS_WR_RESP: begin
        if (s_axi_bready) begin
          next_st.wr = jms_pkg::JMS_WR_IDLE;
        end
      end
    endcase
    next_st.widx = wr_idx;
    next_st.wdata = wr_data;
    next_st.wstrb = wr_strb;
    next_st.awready = next_st.wr == jms_pkg::JMS_WR_IDLE || next_st.wr == jms_pkg::JMS_WR_DATA;
    next_st.wready = next_st.wr == jms_pkg::JMS_WR_IDLE || next_st.wr == jms_pkg::JMS_WR_ADDR;
    next_st.bvalid = next_st.wr == jms_pkg::JMS_WR_RESP;
    // Register updates on a completed write, byte lanes honoured.
    if (do_wr) begin
      next_st.bresp = `JMS_RESP_OKAY;
      unique case (wr_idx)
        `JMS_IDX_CTRL: begin
          if (wr_strb[0]) begin
            next_st.mod_en = wr_data[`JMS_B_EN];
            next_st.mode = jms_pkg::jms_mode_t'(wr_data[`JMS_B_MODE]);
            next_st.no_offset = wr_data[`JMS_B_NOOFS];
            next_st.sw_reset = wr_data[`JMS_B_SWRST];
          end
          if (wr_strb[1]) begin
            next_st.rotate = wr_data[`JMS_B_ROT];
          end
        end
        `JMS_IDX_STAT: next_st.bresp = `JMS_RESP_OKAY;
        `JMS_IDX_IEN: begin
          if (wr_strb[1]) begin
            next_st.ien = wr_data[`JMS_B_VIOL:`JMS_B_TRIG];
          end
        end
        `JMS_IDX_THR: begin
          if (wr_strb[0]) begin
            next_st.thr = wr_data[`JMS_B_THR];
          end
        end
        `JMS_IDX_FSIZE: begin
          if (wr_strb[0]) begin
            next_st.fifo_size[7:0] = wr_data[7:0];
          end
          if (wr_strb[1]) begin
            next_st.fifo_size[15:8] = wr_data[15:8];
          end
        end
        `JMS_IDX_LIM_LO: begin
          if (wr_strb[0]) begin
            next_st.size_limit[7:0] = wr_data[7:0];
          end
          if (wr_strb[1]) begin
            next_st.size_limit[15:8] = wr_data[15:8];
          end
        end
        `JMS_IDX_LIM_HI: begin
          if (wr_strb[0]) begin
            next_st.size_limit[23:16] = wr_data[7:0];
          end
          if (wr_strb[1]) begin
            next_st.size_limit[31:24] = wr_data[15:8];
          end
        end
        `JMS_IDX_RES_LO, `JMS_IDX_RES_HI: next_st.bresp = `JMS_RESP_OKAY;
        default: next_st.bresp = `JMS_RESP_SLVERR;
      endcase
    end
    // Read channel: one read in flight, answered the cycle after it is taken.
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = {16'h0000, rd_val};
      next_st.rresp = rd_hit ? `JMS_RESP_OKAY : `JMS_RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;
    // Routing and interrupt outputs.
    next_st.route = dec_route;
    next_st.irq = |stat_word[`JMS_B_VIOL:`JMS_B_TRIG];
  end

  // State register, synchronous reset, frozen while the clock enable is low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoder and the two sticky flags.
  jms_route_dec u_route_dec (
    .mode(st.mode),
    .enable(st.mod_en),
    .capture_src(capture_src),
    .route(dec_route)
  );

  jms_sticky_flag u_viol_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .cause(viol_cause),
    .clear(clr_viol),
    .soft_reset(st.sw_reset),
    .flag(viol_flag)
  );

  jms_sticky_flag u_trig_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .cause(trig_cause),
    .clear(clr_trig),
    .soft_reset(st.sw_reset),
    .flag(trig_flag)
  );

  // Outputs straight from the state register.
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign route = st.route;
  assign module_clk_en = st.mod_en;
  assign module_sw_reset = st.sw_reset;
  assign yuv_no_offset = st.no_offset;
  assign rotate_180 = st.rotate;
  assign irq = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks of the bank against its cause signals.
  sequence s_ctrl_wr;
    ce && do_wr && wr_idx == `JMS_IDX_CTRL && wr_strb[0];
  endsequence

  sequence s_stat_rd;
    ce && s_axi_arvalid && st.arready && rd_idx == `JMS_IDX_STAT;
  endsequence

  a_route_codec: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st.mod_en && st.mode == jms_pkg::JMS_MODE_CODEC
    |=> route.codec_on && !route.dec_to_host && !route.bypass)
    else $error("mode 000b did not route through the codec");
  a_route_yin: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && (st.mode == jms_pkg::JMS_MODE_YIN_422 || st.mode == jms_pkg::JMS_MODE_YIN_420)
    |=> route.yuv_in && route.bypass && !route.codec_on && route.yuv_420 == $past(st.mode[2]))
    else $error("YUV input mode routed wrongly");
  a_route_yout: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && (st.mode == jms_pkg::JMS_MODE_YOUT_422 || st.mode == jms_pkg::JMS_MODE_YOUT_420)
    |=> route.yuv_out && route.bypass && !route.codec_on && route.yuv_420 == $past(st.mode[2]))
    else $error("YUV output mode routed wrongly");
  a_route_host: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st.mode == jms_pkg::JMS_MODE_HOST_CODEC
    |=> route.line_buf_first && route.enc_src == jms_pkg::JMS_SRC_HOST)
    else $error("host encode path not line buffer first");
  a_host_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st.mode == jms_pkg::JMS_MODE_HOST_CODEC |=> route.dec_to_host)
    else $error("host decode not returned to host");
  a_clk_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ctrl_wr |=> module_clk_en == $past(wr_data[`JMS_B_EN]))
    else $error("module clock enable does not follow bit 0");
  a_gate_cuts: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !st.mod_en |=> !route.codec_on)
    else $error("codec path open while the module is disabled");
  a_soft_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ctrl_wr ##0 wr_data[7] |=> module_sw_reset ##1 (!$past(ce) || !module_sw_reset || $past(do_wr)))
    else $error("soft reset pulse missing");
  a_trig_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st.ien[0] && trig_flag |=> irq)
    else $error("enabled threshold flag raised no interrupt");
  a_fileout_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_stat_rd |=> s_axi_rvalid && s_axi_rdata[14] == $past(codec_stat.file_out))
    else $error("bit 14 does not show codec output activity");
  a_fill_empty: assert property (@(posedge aclk) disable iff (!aresetn)
    s_stat_rd ##0 codec_stat.fifo_bytes <= `JMS_FILL_MIN |=> s_axi_rdata[13:12] == 2'h0)
    else $error("fill level not zero at low fill");
  a_flag_masked: assert property (@(posedge aclk) disable iff (!aresetn)
    s_stat_rd ##0 !st.ien[1] && !st.ien[0] |=> s_axi_rdata[11:10] == 2'h0 && !irq)
    else $error("masked flag visible");
endmodule // jms_top

// *** test/jms_codec_model.sv ***
// Behavioural codec core that presents its status levels to the mode and status bank.
// Assumes the bench names the wanted levels; they reach the block one clock later.
module jms_codec_model (
  input wire logic aclk,
  input wire logic file_out_set,
  input wire logic [15:0] fifo_set,
  input wire logic [31:0] size_set,
  output jms_pkg::jms_codec_stat_t codec_stat
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registers the status as the codec core would drive it.
  always_ff @(posedge aclk) begin
    codec_stat <= '{file_out: file_out_set, fifo_bytes: fifo_set, size_result: size_set};
  end
endmodule // jms_codec_model

// *** test/jms_top_test.sv ***
// Self-checking bench for the mode and status bank, driven as an AXI4-Lite master.
// Assumes the codec model on the status inputs and a 200 MHz clock.
module jms_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] A_CTRL = 16'h2600, A_STAT = 16'h2608, A_IEN = 16'h2618;
  localparam logic [15:0] A_THR = 16'h2680, A_FSZ = 16'h2690, A_LLO = 16'h26C0, A_LHI = 16'h26C8;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [15:0] awaddr, araddr, fifo_set;
  logic [31:0] wdata, rdata, size_set, d;
  logic [1:0] bresp, rresp, wb;
  logic file_out_set, clk_en, sw_rst, irq, no_ofs, rot;
  jms_pkg::jms_src_t csrc;
  jms_pkg::jms_codec_stat_t codec_stat;
  jms_pkg::jms_route_t route;
  int fails = 0;
  int total_checks = 0;
  int pulses = 0;
  logic [15:0] fb [7] = '{16'h0000, 16'h0004, 16'h0005, 16'h0010, 16'h0011, 16'h0020, 16'h0021};
  logic [1:0] fe [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  jms_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .codec_stat(codec_stat),
    .capture_src(csrc), .route(route), .module_clk_en(clk_en),
    .module_sw_reset(sw_rst), .yuv_no_offset(no_ofs), .rotate_180(rot), .irq(irq));
  jms_codec_model model_u (.aclk(aclk), .file_out_set(file_out_set), .fifo_set(fifo_set),
    .size_set(size_set), .codec_stat(codec_stat));
  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock and a count of soft reset pulses.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (sw_rst === 1'b1) pulses++;
  ////////////////////////////////////////////////////////////////////////////
  // Prints the verdict and ends the run.
  task automatic complete_run;
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One write, each channel held until its own ready.
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    wb = bresp;
    bready <= 1'b0;
  endtask
  // One read; the data are taken at the edge where rvalid is seen.
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    rready <= 1'b0;
  endtask
  task automatic settle;
    repeat (2) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    complete_run;
  end
  // Main sequence; the codec register range is never touched.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, file_out_set} = '0;
    {awaddr, araddr, wdata, fifo_set, size_set} = '0;
    csrc = jms_pkg::JMS_SRC_DISPLAY;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_STAT, d);
    chk(d, 32'h0000_8080);
    rd(16'h0000, d);
    chk(rresp, 2'h2);
    chk(d, 32'h0);
    wr(16'h0000, 16'h0000);
    chk(wb, 2'h2);
    wr(A_CTRL, 16'h0001);
    chk(wb, 2'h0);
    settle;
    chk(clk_en, 1'b1);
    for (int m = 0; m < 8; m++) begin
      if (m == 2 || m == 6) continue;
      wr(A_CTRL, {12'h000, m[2:0], 1'b1});
      settle;
      chk({route.codec_on, route.bypass, route.line_buf_first, route.dec_to_host, route.yuv_in, route.yuv_out},
        {m == 0 || m == 4, m[0], m == 4, m == 4, m == 1 || m == 5, m == 3 || m == 7});
      if (m != 4) chk(route.yuv_420, m == 5 || m == 7);
      if (m == 0) begin
        chk(route.enc_src, jms_pkg::JMS_SRC_DISPLAY);
        csrc <= jms_pkg::JMS_SRC_CAMERA;
        settle;
        chk(route.enc_src, jms_pkg::JMS_SRC_CAMERA);
      end
      if (m == 4) chk(route.enc_src, jms_pkg::JMS_SRC_HOST);
    end
    // Codec mode enabled with both option bits, read back whole.
    wr(A_CTRL, 16'h0111);
    settle;
    chk({no_ofs, rot, route.codec_on}, 3'h7);
    rd(A_CTRL, d);
    chk(d, 32'h0000_0111);
    // Clearing the enable last stops the module and its clock.
    wr(A_CTRL, 16'h0000);
    settle;
    chk({clk_en, route.codec_on}, 2'h0);
    wr(A_FSZ, 16'h0040);
    for (int i = 0; i < 7; i++) begin
      fifo_set <= fb[i];
      rd(A_STAT, d);
      chk(d[13:12], fe[i]);
    end
    file_out_set <= 1'b1;
    rd(A_STAT, d);
    chk(d[14], 1'b1);
    // Threshold flag: masked, shown, refused clears, then cleared.
    wr(A_THR, 16'h0020);
    fifo_set <= 16'h000A;
    wr(A_STAT, 16'h0400);
    wr(A_IEN, 16'h0400);
    rd(A_STAT, d);
    chk(d[10], 1'b0);
    wr(A_IEN, 16'h0000);
    fifo_set <= 16'h0014;
    rd(A_STAT, d);
    chk({d[10], irq}, 2'h0);
    wr(A_IEN, 16'h0400);
    rd(A_STAT, d);
    chk({d[10], irq}, 2'h3);
    wr(A_STAT, 16'h0000);
    rd(A_STAT, d);
    chk(d[10], 1'b1);
    wr(A_STAT, 16'h0400);
    rd(A_STAT, d);
    chk(d[10], 1'b1);
    fifo_set <= 16'h000A;
    wr(A_STAT, 16'h0400);
    rd(A_STAT, d);
    chk({d[10], irq}, 2'h0);
    // Size limit flag: set, refused clear, cleared, then soft reset.
    wr(A_IEN, 16'h0C00);
    wr(A_LLO, 16'h0100);
    size_set <= 32'h0000_0101;
    settle;
    rd(A_STAT, d);
    chk(d[11], 1'b1);
    wr(A_STAT, 16'h0800);
    rd(A_STAT, d);
    chk(d[11], 1'b1);
    wr(A_LLO, 16'h0200);
    wr(A_STAT, 16'h0800);
    rd(A_STAT, d);
    chk(d[11], 1'b0);
    size_set <= 32'h0001_0000;
    settle;
    rd(A_STAT, d);
    chk({d[11], irq}, 2'h3);
    size_set <= 32'h0000_0000;
    chk(pulses, 0);
    wr(A_CTRL, 16'h0081);
    rd(A_STAT, d);
    chk(d[11], 1'b0);
    chk(pulses, 1);
    rd(A_CTRL, d);
    chk(d, 32'h0000_0001);
    complete_run;
  end
endmodule // jms_top_test
